// ---- rtl/rxdce_cfg.svh ----
// register offsets, field positions and reset values of the receive extension block
`ifndef RXDCE_CFG_SVH
`define RXDCE_CFG_SVH
// printed offsets are not all word multiples, so they are indices; byte address = index * 4
`define RXDCE_IDX_SYS_CTRL_1 8'h0c
`define RXDCE_IDX_SYS_CTRL_2 8'h0d
`define RXDCE_IDX_SYS_CTRL_3 8'h0e
`define RXDCE_IDX_SLEEP_LO 8'h0f
`define RXDCE_IDX_SLEEP_HI 8'h10
`define RXDCE_IDX_T1_LO 8'h11
`define RXDCE_IDX_T1_HI 8'h12
`define RXDCE_IDX_T2_LO 8'h13
`define RXDCE_IDX_T2_HI 8'h14
`define RXDCE_IDX_EXT_CTRL 8'h15
`define RXDCE_IDX_DET_SEL 8'h16
`define RXDCE_IDX_PHASE_CLK 8'h17
`define RXDCE_IDX_IRQ_STATUS 8'h18
`define RXDCE_IDX_IRQ_MASK 8'h19
`define RXDCE_IDX_STATE 8'h1a
`define RXDCE_IDX_FRONT_END 8'h1b
// field positions
`define RXDCE_RX_TIMER_EN_BIT 4
`define RXDCE_EXT_MODE_LSB 0
`define RXDCE_RSSI_SRC_BIT 4
`define RXDCE_START_BIT 0
// reset values
`define RXDCE_RST_BYTE 8'h00
`define RXDCE_RST_FRONT_END 8'h65
// interrupt status bits
`define RXDCE_IRQ_EXTEND 0
`define RXDCE_IRQ_T1_DONE 1
`define RXDCE_IRQ_T2_DONE 2
`define RXDCE_IRQ_HANDOFF 3
`define RXDCE_IRQ_W 4
// timer tick: one interval unit and one pclk period, both in ns; their ratio gives the pclk cycles per unit
`define RXDCE_TICK_NS 1000
`define RXDCE_CLK_NS 10
`endif

// ---- rtl/rxdce_pkg.sv ----
// types of the receive extension block
package rxdce_pkg;
  typedef enum logic [2:0] {
    RXDCE_IDLE,
    RXDCE_T1,
    RXDCE_T2,
    RXDCE_HOLD,
    RXDCE_HOST
  } rxdce_state_t;
endpackage

// ---- rtl/rxdce_top.sv ----
// receive window extension logic with apb register file
// What this block does
// [RULE1] mode 8 extends when preamble found or sync found occurs during t1.
// [RULE2] mode 9 extends when preamble found or node match occurs during t1.
// [RULE3] mode 10 extends on preamble found, sync found or node match during t1.
// [RULE4] modes 9 and 10 leave t1 for t2 on the condition and end reception when t2 expires.
// [RULE5] modes 11 to 13 run t2, hand to the host on sync, else end reception at t2 expiry.
// [RULE6] modes 11, 12, 13 use signal strength, preamble, and both together as condition.
// [RULE7] mode 7 needs signal strength valid and preamble found at the same time.
// [RULE8] t1 and t2 lengths come from host-written registers.
// [RULE9] signal strength valid comes from a threshold compare or the phase jump detector.
// [RULE10] the host picks front-end power with four 2-bit fields in three documented sets.
// [RULE11] mode 0 gives no extension and reception ends when t1 expires.
// [RULE12] extension applies only while the receive timer enable bit is 1; t2 and hold here ignore the bit and run on once it clears.
// [RULE13] modes 5 to 8 follow the t1-to-t2 behaviour of modes 9 and 10.
//
// Chosen here: register access over APB.
`include "rxdce_cfg.svh"
module rxdce_top
  import rxdce_pkg::*;
#(
  parameter int TICK_CYCLES = `RXDCE_TICK_NS / `RXDCE_CLK_NS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] signal_strength,
  input wire logic phase_jump_detector,
  input wire logic preamble_found,
  input wire logic sync_found,
  input wire logic node_match,
  output logic rx_active,
  output logic host_control,
  output logic [7:0] front_end_power,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [15:0] sleep_len;
    logic [15:0] t1_len;
    logic [15:0] t2_len;
    logic [7:0] ext_ctrl;
    logic [7:0] det_sel;
    logic [7:0] phase_clk;
    logic [7:0] front_end;
    logic [`RXDCE_IRQ_W-1:0] irq_status;
    logic [`RXDCE_IRQ_W-1:0] irq_mask;
    rxdce_state_t state;
    logic [15:0] tick_cnt;
    logic [15:0] win_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_active;
    logic host_control;
    logic irq;
  } rxdce_regs_t;

  rxdce_regs_t r_q;
  rxdce_regs_t r_d;

  localparam logic [15:0] TICK_MAX = 16'(TICK_CYCLES - 1);

  logic access;
  logic [7:0] idx;
  logic aligned;
  logic rssi_valid;
  logic [3:0] mode;
  logic cond;
  logic tick;
  logic [31:0] rd;
  logic hit;

  always_comb
  begin
    r_d = r_q;
    access = psel && penable && !r_q.pready;
    idx = paddr[9:2];
    aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
    mode = r_q.ext_ctrl[`RXDCE_EXT_MODE_LSB +: 4];
    // source of signal strength valid is selectable [RULE9]
    if (r_q.det_sel[`RXDCE_RSSI_SRC_BIT])
    begin
      rssi_valid = phase_jump_detector;
    end
    else
    begin
      rssi_valid = signal_strength >= r_q.phase_clk;
    end
    case (mode)
      4'd1, 4'd4, 4'd5, 4'd11:
      begin
        cond = rssi_valid; // [RULE6]
      end
      4'd2, 4'd6, 4'd12:
      begin
        cond = preamble_found; // [RULE6]
      end
      4'd3, 4'd7, 4'd13:
      begin
        cond = rssi_valid && preamble_found; // [RULE7] [RULE6]
      end
      4'd8:
      begin
        cond = preamble_found || sync_found; // [RULE1]
      end
      4'd9:
      begin
        cond = preamble_found || node_match; // [RULE2]
      end
      4'd10:
      begin
        cond = preamble_found || sync_found || node_match; // [RULE3]
      end
      default:
      begin
        cond = 1'b0; // [RULE11]
      end
    endcase
    tick = (r_q.tick_cnt == TICK_MAX);
    // interval timer ticks
    if (r_q.state == RXDCE_T1 || r_q.state == RXDCE_T2)
    begin
      r_d.tick_cnt = tick ? 16'h0000 : r_q.tick_cnt + 16'h0001;
    end
    else
    begin
      r_d.tick_cnt = 16'h0000;
    end
    case (r_q.state)
      RXDCE_IDLE:
      begin
        if (r_q.ctrl3[`RXDCE_START_BIT] && r_q.ctrl1[`RXDCE_RX_TIMER_EN_BIT]) // [RULE12]
        begin
          r_d.state = RXDCE_T1;
          r_d.win_cnt = r_q.t1_len; // [RULE8]
        end
        // a start given with the timer off is dropped, so it cannot fire later [RULE12]
        r_d.ctrl3[`RXDCE_START_BIT] = 1'b0;
      end
      RXDCE_T1:
      begin
        if (!r_q.ctrl1[`RXDCE_RX_TIMER_EN_BIT])
          r_d.state = RXDCE_IDLE; // [RULE12]
        else if (cond && mode >= 4'd5)
        begin
          r_d.state = RXDCE_T2; // [RULE4] [RULE5] [RULE13]
          r_d.win_cnt = r_q.t2_len; // [RULE8]
          r_d.irq_status[`RXDCE_IRQ_EXTEND] = 1'b1;
        end
        else if (cond && mode == 4'd4)
        begin
          r_d.state = RXDCE_HOLD;
          r_d.irq_status[`RXDCE_IRQ_EXTEND] = 1'b1;
        end
        else if (cond)
        begin
          r_d.state = RXDCE_HOST;
          r_d.irq_status[`RXDCE_IRQ_HANDOFF] = 1'b1;
        end
        else if (r_q.win_cnt == 16'h0000)
        begin
          r_d.state = RXDCE_IDLE; // [RULE11]
          r_d.irq_status[`RXDCE_IRQ_T1_DONE] = 1'b1;
        end
        else if (tick)
        begin
          r_d.win_cnt = r_q.win_cnt - 16'h0001;
        end
      end
      RXDCE_T2:
      begin
        if (mode >= 4'd11 && mode <= 4'd13 && sync_found)
        begin
          r_d.state = RXDCE_HOST; // [RULE5]
          r_d.irq_status[`RXDCE_IRQ_HANDOFF] = 1'b1;
        end
        else if (r_q.win_cnt == 16'h0000)
        begin
          r_d.state = RXDCE_IDLE; // [RULE4] [RULE5]
          r_d.irq_status[`RXDCE_IRQ_T2_DONE] = 1'b1;
        end
        else if (tick)
        begin
          r_d.win_cnt = r_q.win_cnt - 16'h0001;
        end
      end
      RXDCE_HOLD:
      begin
        if (!rssi_valid)
          r_d.state = RXDCE_IDLE;
      end
      RXDCE_HOST:
      begin
        // host ends its own reception by writing 1 to ctrl3 bit 1, which then clears itself
        if (r_q.ctrl3[1])
        begin
          r_d.state = RXDCE_IDLE;
          r_d.ctrl3[1] = 1'b0;
        end
      end
      default:
      begin
        r_d.state = RXDCE_IDLE;
      end
    endcase
    // apb slave: one wait state, registers sit at index * 4
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (idx)
      `RXDCE_IDX_SYS_CTRL_1:
      begin
        rd = {24'h0, r_q.ctrl1};
      end
      `RXDCE_IDX_SYS_CTRL_2:
      begin
        rd = {24'h0, r_q.ctrl2};
      end
      `RXDCE_IDX_SYS_CTRL_3:
      begin
        rd = {24'h0, r_q.ctrl3};
      end
      `RXDCE_IDX_SLEEP_LO:
      begin
        rd = {24'h0, r_q.sleep_len[7:0]};
      end
      `RXDCE_IDX_SLEEP_HI:
      begin
        rd = {24'h0, r_q.sleep_len[15:8]};
      end
      `RXDCE_IDX_T1_LO:
      begin
        rd = {24'h0, r_q.t1_len[7:0]};
      end
      `RXDCE_IDX_T1_HI:
      begin
        rd = {24'h0, r_q.t1_len[15:8]};
      end
      `RXDCE_IDX_T2_LO:
      begin
        rd = {24'h0, r_q.t2_len[7:0]};
      end
      `RXDCE_IDX_T2_HI:
      begin
        rd = {24'h0, r_q.t2_len[15:8]};
      end
      `RXDCE_IDX_EXT_CTRL:
      begin
        rd = {24'h0, r_q.ext_ctrl};
      end
      `RXDCE_IDX_DET_SEL:
      begin
        rd = {24'h0, r_q.det_sel};
      end
      `RXDCE_IDX_PHASE_CLK:
      begin
        rd = {24'h0, r_q.phase_clk};
      end
      `RXDCE_IDX_IRQ_STATUS:
      begin
        rd = {28'h0, r_q.irq_status};
      end
      `RXDCE_IDX_IRQ_MASK:
      begin
        rd = {28'h0, r_q.irq_mask};
      end
      `RXDCE_IDX_STATE:
      begin
        rd = {29'h0, r_q.state};
      end
      `RXDCE_IDX_FRONT_END:
      begin
        rd = {24'h0, r_q.front_end};
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    hit = hit && aligned;
    r_d.pready = access;
    r_d.pslverr = access && !hit;
    r_d.prdata = (access && !pwrite && hit) ? rd : 32'h0000_0000;
    if (access && hit && !pwrite && idx == `RXDCE_IDX_IRQ_STATUS)
      r_d.irq_status = r_q.irq_status & ~r_q.irq_status | (r_d.irq_status & ~r_q.irq_status);
    if (access && hit && pwrite && pstrb[0])
    begin
      case (idx)
        `RXDCE_IDX_SYS_CTRL_1:
        begin
          r_d.ctrl1 = pwdata[7:0];
        end
        `RXDCE_IDX_SYS_CTRL_2:
        begin
          r_d.ctrl2 = pwdata[7:0];
        end
        `RXDCE_IDX_SYS_CTRL_3:
        begin
          r_d.ctrl3 = pwdata[7:0];
        end
        `RXDCE_IDX_SLEEP_LO:
        begin
          r_d.sleep_len[7:0] = pwdata[7:0];
        end
        `RXDCE_IDX_SLEEP_HI:
        begin
          r_d.sleep_len[15:8] = pwdata[7:0];
        end
        `RXDCE_IDX_T1_LO:
        begin
          r_d.t1_len[7:0] = pwdata[7:0]; // [RULE8]
        end
        `RXDCE_IDX_T1_HI:
        begin
          r_d.t1_len[15:8] = pwdata[7:0]; // [RULE8]
        end
        `RXDCE_IDX_T2_LO:
        begin
          r_d.t2_len[7:0] = pwdata[7:0]; // [RULE8]
        end
        `RXDCE_IDX_T2_HI:
        begin
          r_d.t2_len[15:8] = pwdata[7:0]; // [RULE8]
        end
        `RXDCE_IDX_EXT_CTRL:
        begin
          r_d.ext_ctrl = pwdata[7:0];
        end
        `RXDCE_IDX_DET_SEL:
        begin
          r_d.det_sel = pwdata[7:0];
        end
        `RXDCE_IDX_PHASE_CLK:
        begin
          r_d.phase_clk = pwdata[7:0];
        end
        `RXDCE_IDX_IRQ_MASK:
        begin
          r_d.irq_mask = pwdata[`RXDCE_IRQ_W-1:0];
        end
        `RXDCE_IDX_FRONT_END:
        begin
          r_d.front_end = pwdata[7:0]; // [RULE10]
        end
        default:
        begin
          r_d.ctrl2 = r_q.ctrl2;
        end
      endcase
    end
    r_d.rx_active = (r_d.state == RXDCE_T1) || (r_d.state == RXDCE_T2) || (r_d.state == RXDCE_HOLD);
    r_d.host_control = (r_d.state == RXDCE_HOST);
    r_d.irq = |(r_d.irq_status & r_d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_q <= '0;
      r_q.front_end <= `RXDCE_RST_FRONT_END;
      r_q.state <= RXDCE_IDLE;
    end
    else
      r_q <= r_d;
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign rx_active = r_q.rx_active;
  assign host_control = r_q.host_control;
  assign front_end_power = r_q.front_end;
  assign irq = r_q.irq;
endmodule

// ---- verif/rxdce_properties.sv ----
// port-level checks of the receive extension block
module rxdce_properties #(parameter int TICK_CYCLES = 100) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_active,
  input wire logic host_control,
  input wire logic [7:0] front_end_power,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr38;
  logic tmr_q;
  assign wr38 = psel && penable && pready && pwrite && paddr == 32'h0000_0038;
  // mirror of the timer enable, so the gate check needs no register read
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tmr_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 32'h0000_0030)
      tmr_q <= pwdata[4];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  access_wait_a: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("no answer after one wait state");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error without answer");
  fe_write_a: assert property (
    pready && pwrite && paddr == 32'h0000_006c |=> ##[0:1] front_end_power == $past(pwdata[7:0]))
    else $error("front end setting not applied");
  start_cause_a: assert property ($rose(rx_active) |-> $past(wr38) || $past(wr38, 2))
    else $error("reception began without a start");
  tmr_gate_a: assert property (wr38 && pwdata[0] && !tmr_q |=> !rx_active [*3])
    else $error("reception began with timer off");
  host_quit_a: assert property (host_control && wr38 && pwdata[1] |=> ##[0:1] !host_control)
    else $error("host hand-back ignored");
  host_excl_a: assert property (host_control |-> !rx_active)
    else $error("host control while receiving");
  irq_clear_a: assert property (pready && !pwrite && paddr == 32'h0000_0060 && !rx_active
    |=> ##[0:1] !irq)
    else $error("status read left irq set");
endmodule

// ---- verif/rxdce_host_model.sv ----
// apb host that configures and commands the receive extension block
module rxdce_host_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rd;
  logic er;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b000, 64'h0, 4'hf};
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // low, medium and high front-end power sets
  task automatic fe_set(input int lvl);
    logic [7:0] v [3] = '{8'ha5, 8'ha6, 8'h6e};
    xfer(1'b1, 32'h0000_006c, {24'h0, v[lvl]});
  endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the receive extension block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rx_active, host_control, irq;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] signal_strength = 8'h00;
  logic [7:0] front_end_power;
  logic phase_jump_detector = 1'b0, preamble_found = 1'b0, sync_found = 1'b0, node_match = 1'b0;
  int err_total = 0, n_compared = 0, cyc = 0;
  int md [10] = '{0, 5, 6, 7, 8, 9, 10, 11, 12, 13};
  always #5 pclk = ~pclk;
  rxdce_top #(.TICK_CYCLES(2)) dut_u (.*);
  rxdce_host_model host_u (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      end_of_test;
    end
  end
  function automatic logic cond(int m, logic sv, logic p, logic s, logic n);
    case (m)
      5: cond = sv;
      6: cond = p;
      7: cond = sv & p;
      8: cond = p | s;
      9: cond = p | n;
      10: cond = p | s | n;
      11: cond = sv;
      12: cond = p;
      13: cond = sv & p;
      default: cond = 1'b0;
    endcase
  endfunction
  // in: mask, source, strong, phase, preamble, sync, node; hs adds a sync inside t2
  task automatic run(input int m, input logic [6:0] in, input logic hs);
    logic ext;
    int t0;
    if (m > 10)
      in[1] = 1'b0;
    ext = cond(m, in[5] ? in[3] : in[4], in[2], in[1], in[0]);
    host_u.xfer(1'b1, 32'h0000_0054, 32'(m));
    host_u.xfer(1'b1, 32'h0000_0058, {27'h0, in[5], 4'h0});
    host_u.xfer(1'b1, 32'h0000_0064, {28'h0, {4{in[6]}}});
    host_u.xfer(1'b1, 32'h0000_0038, 32'h0000_0001);
    t0 = cyc;
    signal_strength <= in[4] ? 8'hff : 8'h00;
    {phase_jump_detector, preamble_found, sync_found, node_match} <= in[3:0];
    repeat (3) @(posedge pclk);
    {signal_strength, phase_jump_detector, preamble_found, sync_found, node_match} <= 12'h000;
    if (hs)
    begin
      repeat (2) @(posedge pclk);
      sync_found <= 1'b1;
      repeat (2) @(posedge pclk);
      sync_found <= 1'b0;
      repeat (2) @(posedge pclk);
      check(host_control, 1);
      host_u.xfer(1'b0, 32'h0000_0060, 0);
      check(host_u.rd[3:0], 4'h9);
      host_u.xfer(1'b1, 32'h0000_0038, 32'h0000_0002);
    end
    for (int k = 0; k < 2000 && rx_active === 1'b1; k++)
      @(posedge pclk);
    if (!hs)
    begin
      if (!ext)
        check(cyc - t0 inside {[515:519]}, 1);
      check(irq, in[6]);
      host_u.xfer(1'b0, 32'h0000_0060, 0);
      check(host_u.rd[3:0], ext ? 4'h5 : 4'h2);
      check(irq, 0);
    end
    $display("window mode %0d done", m);
  endtask
  initial
  begin
    void'($urandom(73902));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    host_u.xfer(1'b0, 32'h0000_006c, 0);
    check(host_u.rd, 32'h0000_0065);
    host_u.xfer(1'b0, 32'h0000_0100, 0);
    check({host_u.er, host_u.rd[7:0]}, 9'h100);
    for (int i = 0; i < 3; i++)
      host_u.fe_set(i);
    // t1 = 0x0102 ticks, so the high byte counts; t2 = 5 ticks
    host_u.xfer(1'b1, 32'h0000_0044, 32'h0000_0002);
    host_u.xfer(1'b1, 32'h0000_0048, 32'h0000_0001);
    host_u.xfer(1'b1, 32'h0000_004c, 32'h0000_0005);
    host_u.xfer(1'b1, 32'h0000_0050, 32'h0000_0000);
    host_u.xfer(1'b1, 32'h0000_005c, 32'h0000_0080);
    host_u.xfer(1'b1, 32'h0000_0038, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check(rx_active, 0);
    host_u.xfer(1'b1, 32'h0000_0030, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    check(rx_active, 0);
    foreach (md[j])
      run(md[j], 7'h7f, 1'b0);
    run(8, 7'h41, 1'b0);
    run(12, 7'h44, 1'b1);
    for (int i = 0; i < 24; i++)
      run(md[$urandom % 10], 7'($urandom), 1'b0);
    end_of_test;
  end
endmodule
bind rxdce_top rxdce_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
